//--- hdl/aicc_consts.vh
// constants for the audio input and clock configuration block
// assumes a 125 MHz core-side clock and an 8-bit register port
`ifndef AICC_CONSTS_VH
`define AICC_CONSTS_VH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define AICC_ADDR_CLKPROT 8'h00
`define AICC_ADDR_SERIAL 8'h01
`define AICC_ADDR_OUTSTG 8'h02
`define AICC_RST_CLKPROT 8'h63
`define AICC_RST_SERIAL 8'h80
`define AICC_RST_OUTSTG 8'h97
`define AICC_OUTSTG_WMASK 8'hbf
`define AICC_RDATA_NONE 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define AICC_F_CLKSEL 2:0
`define AICC_F_INTERP 4:3
`define AICC_B_TW_RECOV 5
`define AICC_B_TW_ADJ 6
`define AICC_B_FDR_BYP 7
`define AICC_F_FORMAT 3:0
`define AICC_B_BITORDER 4
`define AICC_B_SCK_DLY 5
`define AICC_B_CH1_MAP 6
`define AICC_B_CH2_MAP 7
`define AICC_F_OMODE 1:0
`define AICC_F_CSIZE 5:2
`define AICC_B_OC_BYP 7

// ----------------------------------------
// clock ratio, core clock and format codes
// ----------------------------------------
`define AICC_MCS_576 3'h5
`define AICC_MCS_128 3'h4
`define AICC_MCS_256 3'h3
`define AICC_MCS_384 3'h2
`define AICC_MCS_512 3'h1
`define AICC_MCS_768 3'h0
`define AICC_FAM_32K 2'h0
`define AICC_FAM_44K 2'h1
`define AICC_FAM_48K 2'h2
`define AICC_CORE_HZ_32K 26'h1f40000
`define AICC_CORE_HZ_44K 26'h2b11000
`define AICC_CORE_HZ_48K 26'h2ee0000
`define AICC_FMT_I2S 2'h0
`define AICC_FMT_LJ 2'h1
`define AICC_W24 5'h18
`define AICC_W20 5'h14
`define AICC_W18 5'h12
`define AICC_W16 5'h10
`define AICC_SYNC_TOL 16'h0004
`define AICC_WARN_LIMIT_ADDR 8'h37
`define AICC_PULSE_TICK_NS 9'h014

// ----------------------------------------
// timing
// ----------------------------------------
`define AICC_CLK_PERIOD_NS 8
`define AICC_TW_PERSIST_MS 400
`define AICC_TW_PERSIST_CYC (`AICC_TW_PERSIST_MS * 1000000 / `AICC_CLK_PERIOD_NS)
`define AICC_FDR_UNIT_NS 100000
`define AICC_FDR_UNIT_CYC (`AICC_FDR_UNIT_NS / `AICC_CLK_PERIOD_NS)

`endif

//--- hdl/aicc_top.v
// serial audio input front end, clock ratio decode and protection control
// assumes a same-clock register port from the control bus slave and a
// serial audio master driving frame clock, bit clock and data pins
`timescale 1ns/1ps
`include "aicc_consts.vh"

module aicc_top #(
	parameter TW_PERSIST_CYCLES = `AICC_TW_PERSIST_CYC,
	parameter FDR_UNIT_CYCLES = `AICC_FDR_UNIT_CYC
) (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire i_reg_wr,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	output reg [7:0] o_reg_rdata,
	input wire i_frame_clock_in,
	input wire i_bit_clock_in,
	input wire i_serial_data_in,
	input wire i_pll_locked,
	input wire i_fault,
	input wire i_thermal_warn,
	input wire i_input_detect_enable,
	input wire [15:0] i_fault_recovery_time,
	input wire [15:0] i_expected_ratio,
	input wire [1:0] i_rate_family,
	output reg [23:0] o_ch1_sample,
	output reg [23:0] o_ch2_sample,
	output reg o_sample_valid,
	output reg o_input_mute,
	output reg o_out_tristate,
	output reg o_int_n,
	output reg o_limit_active,
	output reg [7:0] o_limit_coef_addr,
	output reg [9:0] o_pll_factor,
	output reg [25:0] o_core_clk_hz,
	output reg [1:0] o_interp_ratio_sel,
	output reg [1:0] o_output_timing_mode,
	output reg [8:0] o_comp_pulse_ns,
	output reg o_overcurrent_adjust_bypass
);

	localparam [2:0] F_IDLE = 3'b001;
	localparam [2:0] F_HOLD = 3'b010;
	localparam [2:0] F_REL = 3'b100;
	localparam NSYNC = 6;

	reg [7:0] clkprot_q;
	reg [7:0] serial_q;
	reg [7:0] outstg_q;
	reg [NSYNC-1:0] sync1_q;
	reg [NSYNC-1:0] sync2_q;
	wire [NSYNC-1:0] async_in;
	wire lr_s;
	wire bclk_s;
	wire sd_s;
	wire lock_s;
	wire fault_s;
	wire warn_s;
	reg sync_ok_q;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	// writes land on the cycle of the strobe, read data one cycle later
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			clkprot_q <= `AICC_RST_CLKPROT;
			serial_q <= `AICC_RST_SERIAL;
			outstg_q <= `AICC_RST_OUTSTG;
			o_reg_rdata <= `AICC_RDATA_NONE;
		end else if (i_clk_en) begin
			if (i_reg_wr && i_reg_addr == `AICC_ADDR_CLKPROT)
				clkprot_q <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == `AICC_ADDR_SERIAL)
				serial_q <= i_reg_wdata;
			if (i_reg_wr && i_reg_addr == `AICC_ADDR_OUTSTG)
				outstg_q <= i_reg_wdata & `AICC_OUTSTG_WMASK;
			case (i_reg_addr)
			`AICC_ADDR_CLKPROT: o_reg_rdata <= clkprot_q;
			`AICC_ADDR_SERIAL: o_reg_rdata <= serial_q;
			`AICC_ADDR_OUTSTG: o_reg_rdata <= outstg_q;
			default: o_reg_rdata <= `AICC_RDATA_NONE;
			endcase
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign async_in = {i_thermal_warn, i_fault, i_pll_locked,
		i_serial_data_in, i_bit_clock_in, i_frame_clock_in};

	// two flops per pin, the first read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge i_clock) begin
				if (!i_rst_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else if (i_clk_en) begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign lr_s = sync2_q[0];
	assign bclk_s = sync2_q[1];
	assign sd_s = sync2_q[2];
	assign lock_s = sync2_q[3];
	assign fault_s = sync2_q[4];
	assign warn_s = sync2_q[5];

	// ----------------------------------------
	// clock ratio and core clock decode
	// ----------------------------------------
	reg [9:0] base_factor;
	reg [9:0] factor_d;
	reg [25:0] core_hz_d;

	// base-rate factor, halved at double rate, quartered at quad rate, zero for 576 at either
	always @* begin
		case (clkprot_q[`AICC_F_CLKSEL])
		`AICC_MCS_576: base_factor = 10'd576;
		`AICC_MCS_128: base_factor = 10'd128;
		`AICC_MCS_256: base_factor = 10'd256;
		`AICC_MCS_384: base_factor = 10'd384;
		`AICC_MCS_512: base_factor = 10'd512;
		`AICC_MCS_768: base_factor = 10'd768;
		default: base_factor = 10'd0;
		endcase
		if (clkprot_q[`AICC_F_INTERP] != 2'b00 &&
			clkprot_q[`AICC_F_CLKSEL] == `AICC_MCS_576)
			factor_d = 10'd0;
		else if (clkprot_q[4])
			factor_d = {2'b00, base_factor[9:2]};
		else if (clkprot_q[3])
			factor_d = {1'b0, base_factor[9:1]};
		else
			factor_d = base_factor;
		case (i_rate_family)
		`AICC_FAM_32K: core_hz_d = `AICC_CORE_HZ_32K;
		`AICC_FAM_44K: core_hz_d = `AICC_CORE_HZ_44K;
		`AICC_FAM_48K: core_hz_d = `AICC_CORE_HZ_48K;
		default: core_hz_d = `AICC_CORE_HZ_48K;
		endcase
	end

	// configuration seen by the processing and output stages
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_pll_factor <= 10'h000;
			o_core_clk_hz <= 26'h0000000;
			o_interp_ratio_sel <= 2'h0;
			o_output_timing_mode <= 2'h3;
			o_comp_pulse_ns <= 9'h000;
			o_overcurrent_adjust_bypass <= 1'b1;
			o_limit_coef_addr <= 8'h00;
		end else if (i_clk_en) begin
			o_pll_factor <= factor_d;
			o_core_clk_hz <= core_hz_d;
			o_interp_ratio_sel <= clkprot_q[`AICC_F_INTERP];
			o_output_timing_mode <= outstg_q[`AICC_F_OMODE];
			o_comp_pulse_ns <= (outstg_q[`AICC_F_OMODE] == 2'b11) ?
				({5'h00, outstg_q[`AICC_F_CSIZE]} * `AICC_PULSE_TICK_NS) :
				9'h000;
			o_overcurrent_adjust_bypass <= outstg_q[`AICC_B_OC_BYP];
			o_limit_coef_addr <= `AICC_WARN_LIMIT_ADDR;
		end
	end

	// ----------------------------------------
	// serial audio receiver (slave only)
	// ----------------------------------------
	wire [1:0] fmt_kind;
	wire lsb_first;
	wire is_i2s;
	wire rj;
	reg [4:0] fmt_w;
	reg bclk_dly_q;
	reg bclk_prev_q;
	reg lr_prev_q;
	reg [23:0] sr_q;
	reg [4:0] idx_q;
	reg [4:0] cnt_q;
	reg [23:0] left_q;
	wire bclk_use;
	wire bclk_rise;
	wire lr_change;
	wire [4:0] off;
	wire [4:0] wcap;
	wire cap;
	reg [23:0] word;

	assign fmt_kind = serial_q[1:0];
	assign lsb_first = serial_q[`AICC_B_BITORDER];
	assign is_i2s = (fmt_kind == `AICC_FMT_I2S);
	assign rj = ~fmt_kind[0] & fmt_kind[1];

	// width from the upper format bits
	always @* begin
		case (serial_q[3:2])
		2'b00: fmt_w = `AICC_W24;
		2'b01: fmt_w = `AICC_W20;
		2'b10: fmt_w = `AICC_W18;
		default: fmt_w = `AICC_W16;
		endcase
	end

	// optional one-cycle bit clock delay, then edge find
	assign bclk_use = serial_q[`AICC_B_SCK_DLY] ? bclk_dly_q : bclk_s;
	assign bclk_rise = bclk_use & ~bclk_prev_q;
	assign lr_change = lr_s ^ lr_prev_q;
	assign off = is_i2s ? 5'd1 : 5'd0;
	assign wcap = lsb_first ? fmt_w : `AICC_W24;
	// leading-aligned formats keep a window, right-justified keeps the tail
	assign cap = rj | ((idx_q >= off) && (idx_q < off + wcap));

	// align the half-frame word so its msb lands on bit 23
	always @* begin
		word = 24'h000000;
		if (lsb_first)
			word = sr_q & ~(24'hffffff >> fmt_w);
		else if (rj)
			word = (sr_q & (24'hffffff >> (5'd24 - fmt_w)))
				<< (5'd24 - fmt_w);
		else
			word = sr_q << (5'd24 - cnt_q);
	end

	wire closing_left;
	wire mute;
	assign closing_left = is_i2s ? ~lr_prev_q : lr_prev_q;
	assign mute = i_input_detect_enable & ~(lock_s & sync_ok_q);

	// bits are taken on bit clock rising edges seen in the core clock
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			bclk_dly_q <= 1'b0;
			bclk_prev_q <= 1'b0;
			lr_prev_q <= 1'b0;
			sr_q <= 24'h000000;
			idx_q <= 5'h00;
			cnt_q <= 5'h00;
			left_q <= 24'h000000;
			o_ch1_sample <= 24'h000000;
			o_ch2_sample <= 24'h000000;
			o_sample_valid <= 1'b0;
		end else if (i_clk_en) begin
			bclk_dly_q <= bclk_s;
			bclk_prev_q <= bclk_use;
			o_sample_valid <= 1'b0;
			if (bclk_rise) begin
				lr_prev_q <= lr_s;
				if (lr_change) begin
					// close the half-frame, bit 0 of the next one
					if (closing_left)
						left_q <= word;
					else if (!mute) begin
						o_ch1_sample <= serial_q[`AICC_B_CH1_MAP] ?
							word : left_q;
						o_ch2_sample <= serial_q[`AICC_B_CH2_MAP] ?
							word : left_q;
						o_sample_valid <= 1'b1;
					end else begin
						o_ch1_sample <= 24'h000000;
						o_ch2_sample <= 24'h000000;
					end
					idx_q <= 5'h01;
					if (!is_i2s) begin
						sr_q <= lsb_first ? {sd_s, 23'h000000} :
							{23'h000000, sd_s};
						cnt_q <= 5'h01;
					end else begin
						sr_q <= 24'h000000;
						cnt_q <= 5'h00;
					end
				end else begin
					if (idx_q != 5'h1f)
						idx_q <= idx_q + 5'h01;
					if (cap) begin
						sr_q <= lsb_first ? {sd_s, sr_q[23:1]} :
							{sr_q[22:0], sd_s};
						if (cnt_q != `AICC_W24)
							cnt_q <= cnt_q + 5'h01;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// frame clock ratio check
	// ----------------------------------------
	reg lr_seen_q;
	reg [15:0] period_q;
	wire lr_edge;
	wire [15:0] lo_lim;
	wire [15:0] hi_lim;
	assign lr_edge = lr_s & ~lr_seen_q;
	assign lo_lim = i_expected_ratio - `AICC_SYNC_TOL;
	assign hi_lim = i_expected_ratio + `AICC_SYNC_TOL;

	// core cycles per frame must stay inside N-4..N+4
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			lr_seen_q <= 1'b0;
			period_q <= 16'h0000;
			sync_ok_q <= 1'b0;
			o_input_mute <= 1'b0;
		end else if (i_clk_en) begin
			lr_seen_q <= lr_s;
			o_input_mute <= mute;
			if (lr_edge) begin
				period_q <= 16'h0001;
				sync_ok_q <= (period_q >= lo_lim) &&
					(period_q <= hi_lim);
			end else begin
				if (period_q != 16'hffff)
					period_q <= period_q + 16'h0001;
				if (period_q > hi_lim)
					sync_ok_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// fault recovery and interrupt pulse
	// ----------------------------------------
	reg [2:0] fstate_q;
	reg fault_prev_q;
	reg [15:0] unit_q;
	reg [31:0] tick_q;
	wire [15:0] units;
	assign units = (i_fault_recovery_time == 16'h0000) ? 16'h0001 :
		i_fault_recovery_time;

	// tristate held for the programmed time, retried while fault stays
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			fstate_q <= F_IDLE;
			fault_prev_q <= 1'b0;
			unit_q <= 16'h0000;
			tick_q <= 32'h00000000;
			o_out_tristate <= 1'b0;
			o_int_n <= 1'b1;
		end else if (i_clk_en) begin
			fault_prev_q <= fault_s;
			o_int_n <= ~(fault_s & ~fault_prev_q);
			case (fstate_q)
			F_IDLE: begin
				if (fault_s && !clkprot_q[`AICC_B_FDR_BYP]) begin
					fstate_q <= F_HOLD;
					o_out_tristate <= 1'b1;
					unit_q <= units;
					tick_q <= FDR_UNIT_CYCLES - 1;
				end
			end
			F_HOLD: begin
				if (tick_q != 32'h00000000)
					tick_q <= tick_q - 32'h00000001;
				else if (unit_q != 16'h0001) begin
					unit_q <= unit_q - 16'h0001;
					tick_q <= FDR_UNIT_CYCLES - 1;
				end else begin
					fstate_q <= F_REL;
					o_out_tristate <= 1'b0;
				end
			end
			F_REL: fstate_q <= F_IDLE;
			default: begin
				fstate_q <= F_IDLE;
				o_out_tristate <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// thermal warning limiting
	// ----------------------------------------
	reg [31:0] warn_cnt_q;

	// persist timer, then limit; release depends on recovery bypass
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			warn_cnt_q <= 32'h00000000;
			o_limit_active <= 1'b0;
		end else if (i_clk_en) begin
			if (!warn_s)
				warn_cnt_q <= 32'h00000000;
			else if (warn_cnt_q != TW_PERSIST_CYCLES)
				warn_cnt_q <= warn_cnt_q + 32'h00000001;
			if (clkprot_q[`AICC_B_TW_ADJ])
				o_limit_active <= 1'b0;
			else if (warn_s && warn_cnt_q == TW_PERSIST_CYCLES)
				o_limit_active <= 1'b1;
			else if (!warn_s && !clkprot_q[`AICC_B_TW_RECOV])
				o_limit_active <= 1'b0;
		end
	end

endmodule

//--- sim/aicc_props.sv
// assertions on the ports of the audio input and clock configuration block
// assumes binding to aicc_top with the clock enable held high
`timescale 1ns/1ps
module aicc_props #(
	parameter TW_PERSIST_CYCLES = 100,
	parameter FDR_UNIT_CYCLES = 4
) (
	input wire i_clock,
	input wire i_rst_n,
	input wire [7:0] i_reg_addr,
	input wire i_fault,
	input wire i_thermal_warn,
	input wire i_input_detect_enable,
	input wire [15:0] i_fault_recovery_time,
	input wire [7:0] o_reg_rdata,
	input wire o_sample_valid,
	input wire o_input_mute,
	input wire o_out_tristate,
	input wire o_int_n,
	input wire o_limit_active,
	input wire [7:0] o_limit_coef_addr,
	input wire [1:0] o_output_timing_mode,
	input wire [8:0] o_comp_pulse_ns
);
	reg [31:0] warn_q;
	reg [31:0] tri_q;
	wire [31:0] hold_w;

	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	assign hold_w = FDR_UNIT_CYCLES * ((i_fault_recovery_time == 16'h0000) ?
		32'h1 : {16'h0000, i_fault_recovery_time});
	// cycles of warning pin and of tristate held
	always @(posedge i_clock) begin
		if (!i_rst_n) begin
			warn_q <= 32'h0;
			tri_q <= 32'h0;
		end else begin
			warn_q <= i_thermal_warn ? warn_q + 32'h1 : 32'h0;
			tri_q <= o_out_tristate ? tri_q + 32'h1 : 32'h0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_low_pulse;
		!o_int_n ##1 o_int_n;
	endsequence
	sequence s_detect_off;
		!i_input_detect_enable ##1 !i_input_detect_enable;
	endsequence
	chk_int_pulse: assert property ($fell(o_int_n) |-> s_low_pulse)
		else $error("interrupt low longer than one cycle");
	chk_int_cause: assert property ($fell(o_int_n) |-> $past(i_fault, 3))
		else $error("interrupt pulse without fault");
	chk_tri_cause: assert property ($rose(o_out_tristate) |-> $past(i_fault, 3))
		else $error("tristate without fault");
	chk_tri_hold: assert property ($fell(o_out_tristate) |->
		tri_q >= hold_w && tri_q <= 2 * hold_w + 8)
		else $error("tristate hold length wrong");
	chk_limit_wait: assert property ($rose(o_limit_active) |->
		warn_q >= TW_PERSIST_CYCLES)
		else $error("limit applied too early");
	chk_limit_entry: assert property (o_limit_active |->
		o_limit_coef_addr == 8'h37)
		else $error("limit coefficient entry wrong");
	chk_mute_off: assert property (s_detect_off |=> !o_input_mute)
		else $error("mute without detect enable");
	chk_mute_novalid: assert property (o_input_mute |-> !o_sample_valid)
		else $error("sample valid while muted");
	chk_valid_pulse: assert property (o_sample_valid |=> !o_sample_valid)
		else $error("sample valid longer than one cycle");
	chk_reserved_zero: assert property (i_reg_addr == 8'h02 |=>
		!o_reg_rdata[6])
		else $error("reserved bit reads one");
	chk_pulse_mode: assert property (o_output_timing_mode != 2'h3 |->
		o_comp_pulse_ns == 9'h000)
		else $error("pulse size outside variable mode");
endmodule

//--- sim/aicc_src.sv
// serial audio source model, always master of frame and bit clock
// assumes the receiver samples data on bit clock rises, period 125 ns
`timescale 1ns/1ps
module aicc_src (
	output reg o_frame_clock,
	output reg o_bit_clock,
	output reg o_serial_data
);
	// ----------------------------------------
	// idle state and one stereo pair
	// ----------------------------------------
	initial begin
		o_frame_clock = 1'b1;
		o_bit_clock = 1'b0;
		o_serial_data = 1'b0;
	end
	// bit clock stands low outside frames; data moves while it is low
	// a lead bit in the right half makes every frame open on an edge
	task send(input [23:0] l, input [23:0] r, input lj);
		reg [63:0] bits;
		integer i;
		begin
			bits = lj ? {l, 8'h00, r, 8'h00} : {1'b0, l, 8'h00, r, 7'h00};
			for (i = 64; i >= -1; i = i - 1) begin
				o_frame_clock = ((i >= 32 && i < 64) || i < 0) ?
					lj : !lj;
				o_serial_data = (i >= 0 && i < 64) ? bits[i] : 1'b0;
				#62.5 o_bit_clock = 1'b1;
				#62.5 o_bit_clock = 1'b0;
			end
			o_serial_data = !o_serial_data; // data line inverted from its last level
		end
	endtask
endmodule

//--- sim/aicc_top_bench.sv
// self-checking bench for the audio input and clock configuration block
// assumes the source model drives the serial pins, clock enable held high
`timescale 1ns/1ps
module aicc_top_bench;
	reg i_clock = 1'b0;
	reg i_rst_n = 1'b0;
	reg i_reg_wr = 1'b0;
	reg [7:0] i_reg_addr = 8'h00;
	reg [7:0] i_reg_wdata = 8'h00;
	reg i_pll_locked = 1'b1;
	reg i_fault = 1'b0;
	reg i_thermal_warn = 1'b0;
	reg i_input_detect_enable = 1'b0;
	reg [15:0] i_fault_recovery_time = 16'h0002;
	reg [15:0] i_expected_ratio = 16'h03e8;
	reg [1:0] i_rate_family = 2'h0;
	wire i_frame_clock_in, i_bit_clock_in, i_serial_data_in;
	wire [7:0] o_reg_rdata, o_limit_coef_addr;
	wire [23:0] o_ch1_sample, o_ch2_sample;
	wire o_sample_valid, o_input_mute, o_out_tristate, o_int_n;
	wire o_limit_active, o_overcurrent_adjust_bypass;
	wire [9:0] o_pll_factor;
	wire [25:0] o_core_clk_hz;
	wire [1:0] o_interp_ratio_sel, o_output_timing_mode;
	wire [8:0] o_comp_pulse_ns;
	integer fails = 0;
	integer checked = 0;
	integer cycles = 0;
	reg [25:0] nvalid = 26'h0, nint = 26'h0, ntri = 26'h0, n0;
	reg [23:0] got1 = 24'h0, got2 = 24'h0;
	reg tri_d = 1'b0;
	integer a, b;

	aicc_top #(.TW_PERSIST_CYCLES(100), .FDR_UNIT_CYCLES(4)) u_aicc_top (
		.i_clock, .i_rst_n, .i_clk_en(1'b1), .i_reg_wr, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .i_frame_clock_in, .i_bit_clock_in,
		.i_serial_data_in, .i_pll_locked, .i_fault, .i_thermal_warn,
		.i_input_detect_enable, .i_fault_recovery_time, .i_expected_ratio,
		.i_rate_family, .o_ch1_sample, .o_ch2_sample, .o_sample_valid,
		.o_input_mute, .o_out_tristate, .o_int_n, .o_limit_active,
		.o_limit_coef_addr, .o_pll_factor, .o_core_clk_hz,
		.o_interp_ratio_sel, .o_output_timing_mode, .o_comp_pulse_ns,
		.o_overcurrent_adjust_bypass);
	aicc_src u_aicc_src (.o_frame_clock(i_frame_clock_in),
		.o_bit_clock(i_bit_clock_in), .o_serial_data(i_serial_data_in));

	// ----------------------------------------
	// clock, monitor and timeout
	// ----------------------------------------
	always #4 i_clock = !i_clock;
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		tri_d <= o_out_tristate;
		if (o_sample_valid === 1'b1) begin
			got1 <= o_ch1_sample;
			got2 <= o_ch2_sample;
			nvalid <= nvalid + 26'h1;
		end
		if (o_int_n === 1'b0)
			nint <= nint + 26'h1;
		if (o_out_tristate === 1'b1 && !tri_d)
			ntri <= ntri + 26'h1;
		if (cycles == 20000) begin
			fails = fails + 1;
			test_done;
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task cmp(input [25:0] got, input [25:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task idle(input integer n);
		repeat (n) @(negedge i_clock);
	endtask
	task wr(input [7:0] ad, input [7:0] d);
		begin
			@(negedge i_clock);
			i_reg_addr = ad;
			i_reg_wdata = d;
			i_reg_wr = 1'b1;
			@(negedge i_clock);
			i_reg_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] ad, input [7:0] exp);
		begin
			@(negedge i_clock);
			i_reg_addr = ad;
			@(negedge i_clock);
			cmp(o_reg_rdata, exp);
		end
	endtask
	task pair(input [23:0] l, r, input lj, input [23:0] e1, e2);
		begin
			n0 = nvalid;
			u_aicc_src.send(l, r, lj);
			idle(8);
			// the opening edge closes a stale pair: two pulses per frame
			cmp(nvalid - n0, 26'h2);
			cmp(got1, e1);
			cmp(got2, e2);
		end
	endtask
	function [9:0] fbase(input [2:0] c);
		case (c)
		3'h0: fbase = 10'h300;
		3'h1: fbase = 10'h200;
		3'h2: fbase = 10'h180;
		3'h3: fbase = 10'h100;
		3'h4: fbase = 10'h080;
		default: fbase = 10'h240;
		endcase
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		begin
			rd(8'h00, 8'h63);
			rd(8'h01, 8'h80);
			rd(8'h02, 8'h97);
			rd(8'h07, 8'h00);
			wr(8'h02, 8'hff);
			rd(8'h02, 8'hbf);
			cmp(o_overcurrent_adjust_bypass, 1'b1);
		end
	endtask
	task t_pll;
		begin
			for (a = 0; a < 3; a = a + 1) begin
				for (b = 0; b < 6; b = b + 1) begin
					wr(8'h00, {3'b011, a[1:0], b[2:0]});
					idle(3);
					cmp(o_pll_factor, (b == 5 && a != 0) ? 10'h0 :
						fbase(b[2:0]) >> a);
					cmp(o_interp_ratio_sel, a[1:0]);
				end
				i_rate_family = a[1:0];
				idle(3);
				cmp(o_core_clk_hz, (a == 0) ? 26'h1f40000 : (a == 1) ?
					26'h2b11000 : 26'h2ee0000);
			end
			wr(8'h00, 8'h63);
		end
	endtask
	task t_omode;
		for (a = 0; a < 4; a = a + 1) begin
			wr(8'h02, {4'h9, 2'b01, a[1:0]});
			idle(3);
			cmp(o_output_timing_mode, a[1:0]);
			cmp(o_comp_pulse_ns, (a == 3) ? 9'h064 : 9'h000);
		end
	endtask
	task t_link;
		begin
			pair(24'h123456, 24'habcdef, 1'b0, 24'h123456, 24'habcdef);
			wr(8'h01, 8'h40);
			pair(24'h123456, 24'habcdef, 1'b0, 24'habcdef, 24'h123456);
			wr(8'h01, 8'ha1);
			pair(24'h654321, 24'h0f0f0f, 1'b1, 24'h654321, 24'h0f0f0f);
			wr(8'h01, 8'h91);
			pair(24'hd9eac8, 24'h0, 1'b1, 24'h13579b, 24'h0);
			wr(8'h01, 8'h82);
			pair(24'h001234, 24'h005678, 1'b1, 24'h123400, 24'h567800);
			wr(8'h01, 8'h80);
		end
	endtask
	task t_mute;
		begin
			i_pll_locked = 1'b0;
			i_input_detect_enable = 1'b1;
			idle(6);
			cmp(o_input_mute, 1'b1);
			n0 = nvalid;
			u_aicc_src.send(24'h111111, 24'h222222, 1'b0);
			idle(8);
			cmp(nvalid - n0, 26'h0);
			cmp(o_ch1_sample, 24'h0);
			i_input_detect_enable = 1'b0;
			i_pll_locked = 1'b1;
			idle(4);
			cmp(o_input_mute, 1'b0);
		end
	endtask
	task t_fault;
		for (a = 0; a < 2; a = a + 1) begin
			wr(8'h00, a ? 8'he3 : 8'h63);
			n0 = ntri;
			b = nint;
			i_fault = 1'b1;
			idle(40);
			i_fault = 1'b0;
			idle(30);
			cmp(nint - b[25:0], 26'h1);
			cmp((ntri - n0) > 1, a == 0);
		end
	endtask
	task t_thermal;
		begin
			wr(8'h00, 8'h03);
			i_thermal_warn = 1'b1;
			idle(50);
			cmp(o_limit_active, 1'b0);
			idle(70);
			cmp(o_limit_active, 1'b1);
			cmp(o_limit_coef_addr, 8'h37);
			i_thermal_warn = 1'b0;
			idle(6);
			cmp(o_limit_active, 1'b0);
			wr(8'h00, 8'h23);
			i_thermal_warn = 1'b1;
			idle(120);
			i_thermal_warn = 1'b0;
			idle(6);
			cmp(o_limit_active, 1'b1);
			wr(8'h00, 8'h03);
			idle(4);
			cmp(o_limit_active, 1'b0);
		end
	endtask

	// ----------------------------------------
	// main sequence and verdict
	// ----------------------------------------
	task test_done;
		begin
			$display("checked=%0d fails=%0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(negedge i_clock);
		i_rst_n = 1'b1;
		idle(3);
		t_regs;
		t_pll;
		t_omode;
		t_link;
		t_mute;
		t_fault;
		t_thermal;
		test_done;
	end
endmodule

bind aicc_top aicc_props #(.TW_PERSIST_CYCLES(TW_PERSIST_CYCLES),
	.FDR_UNIT_CYCLES(FDR_UNIT_CYCLES)) u_aicc_props (.i_clock, .i_rst_n,
	.i_reg_addr, .i_fault, .i_thermal_warn, .i_input_detect_enable,
	.i_fault_recovery_time, .o_reg_rdata, .o_sample_valid, .o_input_mute,
	.o_out_tristate, .o_int_n, .o_limit_active, .o_limit_coef_addr,
	.o_output_timing_mode, .o_comp_pulse_ns);
